// file: inc/auto_op_pkg.sv
// Constants, types and register map of the automatic operation controller
// Notes on behaviour
// - Falling edge of cycle start request in auto or MDI mode starts operation.
// - Start ignored: wrong mode, e-stop, rewind, reset key, alarm, running, restart, search.
// - No start while feed hold input is held low.
// - Falling edge of feed hold during operation enters hold and stops motion.
// - Single block end, MDI end, alarm or mode change after block stops operation.
// - E-stop low or reset key stops operation and decelerates axes to rest.
// - Releasing feed hold does not resume; a new start request is needed.
// - Entering feed hold clears start lamp and sets hold lamp.
// - Start, hold, running lamps: 1,0,1 start; 0,1,1 hold; 0,0,0 stop and reset.
// - Reset notification rises on e-stop low or reset key.
// - Notification holds for reset processing time plus extra time after release.
// - Reset clears code strobes within sixteen milliseconds.
// - Axis lock blocks servo pulses but block execution continues.
// - Axis lock status mirrors the axis lock request.
// - Dry run in auto or MDI uses dry run feedrate, else programmed.
// - Dry run toggle ramps speed smoothly between the two rates.
// - Single block finishes the current block then stops.
// - Single block low resumes normal sequential execution.
package auto_op_pkg;

   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int SCAN_PERIOD_US = 1000;
   localparam int SCAN_CYCLES = CLK_HZ / 1_000_000 * SCAN_PERIOD_US;
   localparam int STROBE_LIMIT_MS = 16;
   localparam int T_RESET_MS = 16;

   // Mode codes on the mode input
   localparam logic [2:0] MODE_AUTO = 3'h1;
   localparam logic [2:0] MODE_MDI = 3'h2;
   localparam logic [2:0] MODE_EDIT = 3'h3;

   // Register word offsets (byte addresses)
   localparam logic [7:0] REG_RST_EXTRA = 8'h00;
   localparam logic [7:0] REG_DRY_RATE = 8'h04;
   localparam logic [7:0] REG_PROG_RATE = 8'h08;
   localparam logic [7:0] REG_RAMP_STEP = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // Reset values
   localparam logic [15:0] RST_EXTRA_RST = 16'h0000;
   localparam logic [15:0] DRY_RATE_RST = 16'h0100;
   localparam logic [15:0] PROG_RATE_RST = 16'h0080;
   localparam logic [15:0] RAMP_STEP_RST = 16'h0004;

   // Status register field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_LOCK_BIT = 3;
   localparam int STAT_NOTIFY_BIT = 4;
   localparam int STAT_START_BIT = 5;
   localparam int STAT_HOLD_BIT = 6;
   localparam int STAT_RUN_BIT = 7;
   localparam int STAT_STROBE_LSB = 8;
   localparam int STAT_RATE_LSB = 16;

   typedef enum logic [1:0] {
      OP_STOP,
      OP_START,
      OP_HOLD,
      OP_RESET
   } op_state_t;

   // Lamps and running flag travel together
   typedef struct packed {
      logic start;
      logic hold;
      logic running;
   } lamps_t;

   // All state of the controller
   typedef struct packed {
      logic [15:0] ms_cnt;
      logic prev_start;
      logic prev_hold_n;
      op_state_t state;
      logic [2:0] run_mode;
      logic [16:0] rst_cnt;
      logic [15:0] rate;
      lamps_t lamps;
      logic notify;
      logic lock_stat;
      logic pulse_en;
      logic exec_en;
      logic [2:0] strobes;
      logic [15:0] rst_extra;
      logic [15:0] dry_rate;
      logic [15:0] prog_rate;
      logic [15:0] ramp_step;
      logic ack;
      logic [31:0] rdata;
   } ctl_t;

   localparam ctl_t CTL_RST = '{
      ms_cnt: 16'h0000,
      prev_start: 1'b0,
      prev_hold_n: 1'b1,
      state: OP_STOP,
      run_mode: 3'h0,
      rst_cnt: 17'h00000,
      rate: 16'h0000,
      lamps: 3'h0,
      notify: 1'b0,
      lock_stat: 1'b0,
      pulse_en: 1'b0,
      exec_en: 1'b0,
      strobes: 3'h0,
      rst_extra: RST_EXTRA_RST,
      dry_rate: DRY_RATE_RST,
      prog_rate: PROG_RATE_RST,
      ramp_step: RAMP_STEP_RST,
      ack: 1'b0,
      rdata: 32'h00000000
   };

endpackage

// file: src/auto_operation_control.sv
// Automatic operation state control with Wishbone register access
`timescale 1ns/100ps
`default_nettype none
module auto_operation_control
   import auto_op_pkg::*;
#(
   parameter int SCAN_CYCLES_P = SCAN_CYCLES
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic [3:0] SEL_I,
   input wire logic WE_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic [2:0] MODE_I,
   input wire logic CYCLE_START_REQUEST_I,
   input wire logic FEED_HOLD_N_I,
   input wire logic EMERGENCY_STOP_N_I,
   input wire logic RESET_AND_REWIND_I,
   input wire logic RESET_KEY_I,
   input wire logic ALARM_I,
   input wire logic PROGRAM_RESTART_I,
   input wire logic SEQ_SEARCH_I,
   input wire logic BLOCK_DONE_I,
   input wire logic MDI_END_I,
   input wire logic AXIS_LOCK_REQUEST_I,
   input wire logic DRY_RUN_REQUEST_I,
   input wire logic SINGLE_BLOCK_REQUEST_I,
   input wire logic [2:0] CODE_STROBE_SET_I,
   input wire logic CODE_FINISH_I,
   output logic CYCLE_START_LAMP_O,
   output logic FEED_HOLD_LAMP_O,
   output logic AUTO_RUNNING_O,
   output logic RESET_NOTIFY_O,
   output logic AXIS_LOCK_STATUS_O,
   output logic SERVO_PULSE_EN_O,
   output logic BLOCK_EXEC_EN_O,
   output logic MISC_CODE_STROBE_O,
   output logic SPINDLE_CODE_STROBE_O,
   output logic TOOL_CODE_STROBE_O,
   output logic [15:0] FEED_RATE_O
);

   localparam logic [15:0] SCAN_LAST = 16'(SCAN_CYCLES_P - 1);
   localparam logic [16:0] RESET_HOLD = 17'(T_RESET_MS);

   ctl_t s;
   ctl_t next_s;
   logic scan;
   logic start_fall;
   logic hold_fall;
   logic reset_cause;
   logic auto_mode;
   logic start_ok;
   logic mode_leave;
   logic [15:0] target;

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] wmerge(input logic [15:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction

   // Speed one ramp step closer to the target
   function automatic logic [15:0] ramp(input logic [15:0] cur,
      input logic [15:0] tgt, input logic [15:0] step);
      logic [15:0] r;
      r = cur;
      if (cur < tgt) begin
         r = (tgt - cur > step) ? cur + step : tgt;
      end else if (cur > tgt) begin
         r = (cur - tgt > step) ? cur - step : tgt;
      end
      return r;
   endfunction

   // Scan tick and edge detection against previous scan sample
   assign scan = (s.ms_cnt == SCAN_LAST);
   assign start_fall = scan & s.prev_start & ~CYCLE_START_REQUEST_I;
   assign hold_fall = scan & s.prev_hold_n & ~FEED_HOLD_N_I;
   assign reset_cause = ~EMERGENCY_STOP_N_I | RESET_KEY_I;
   assign auto_mode = (MODE_I == MODE_AUTO) | (MODE_I == MODE_MDI);

   // Every blocking condition vetoes a start edge
   assign start_ok = start_fall & auto_mode & EMERGENCY_STOP_N_I
      & ~RESET_AND_REWIND_I & ~RESET_KEY_I & ~ALARM_I
      & ~PROGRAM_RESTART_I & ~SEQ_SEARCH_I
      & FEED_HOLD_N_I;

   // Leaving for another automatic mode or edit waits for block end
   assign mode_leave = BLOCK_DONE_I & (MODE_I != s.run_mode)
      & (auto_mode | (MODE_I == MODE_EDIT));

   // Dry run only counts while operating in auto or MDI
   always_comb begin
      target = 16'h0000;
      if (s.state == OP_START) begin
         if (DRY_RUN_REQUEST_I & auto_mode) begin
            target = s.dry_rate;
         end else begin
            target = s.prog_rate;
         end
      end
   end

   // Next state of the whole controller
   always_comb begin
      next_s = s;
      next_s.ms_cnt = scan ? 16'h0000 : s.ms_cnt + 16'h0001;
      next_s.lock_stat = AXIS_LOCK_REQUEST_I;

      if (scan) begin
         next_s.prev_start = CYCLE_START_REQUEST_I;
         next_s.prev_hold_n = FEED_HOLD_N_I;
         next_s.rate = ramp(s.rate, target, s.ramp_step);
         if (reset_cause) begin
            next_s.state = OP_RESET;
            next_s.rst_cnt = RESET_HOLD + {1'b0, s.rst_extra};
         end else begin
            case (s.state)
               OP_STOP: begin
                  if (start_ok) begin
                     next_s.state = OP_START;
                     next_s.run_mode = MODE_I;
                  end
               end
               OP_START: begin
                  if (hold_fall) begin
                     next_s.state = OP_HOLD;
                  end else if (ALARM_I | mode_leave) begin
                     next_s.state = OP_STOP;
                  end else if (BLOCK_DONE_I & SINGLE_BLOCK_REQUEST_I) begin
                     next_s.state = OP_STOP;
                  end else if (MDI_END_I & (s.run_mode == MODE_MDI)) begin
                     next_s.state = OP_STOP;
                  end
               end
               OP_HOLD: begin
                  // Release of hold alone never resumes
                  if (ALARM_I) begin
                     next_s.state = OP_STOP;
                  end else if (start_ok) begin
                     next_s.state = OP_START;
                     next_s.run_mode = MODE_I;
                  end
               end
               OP_RESET: begin
                  // Count the hold time once the cause has gone
                  if (s.rst_cnt == 17'h00000) begin
                     next_s.state = OP_STOP;
                  end else begin
                     next_s.rst_cnt = s.rst_cnt - 17'h00001;
                  end
               end
               default: begin
                  next_s.state = OP_STOP;
               end
            endcase
         end
      end

      // Lamps follow the state being entered
      case (next_s.state)
         OP_START: next_s.lamps = '{start: 1'b1, hold: 1'b0, running: 1'b1};
         OP_HOLD: next_s.lamps = '{start: 1'b0, hold: 1'b1, running: 1'b1};
         default: next_s.lamps = '{start: 1'b0, hold: 1'b0, running: 1'b0};
      endcase
      next_s.notify = (next_s.state == OP_RESET);
      next_s.exec_en = (next_s.state == OP_START);
      next_s.pulse_en = (next_s.state == OP_START)
         & ~AXIS_LOCK_REQUEST_I;

      // Code strobes: set by the sequencer, cleared by finish or reset
      next_s.strobes = s.strobes | CODE_STROBE_SET_I;
      // A set arriving with finish survives, so no code is lost
      if (CODE_FINISH_I) begin
         next_s.strobes = CODE_STROBE_SET_I;
      end
      if (scan & reset_cause) begin
         next_s.strobes = 3'h0;
      end

      // Wishbone slave: ack one cycle after request, drops next cycle
      next_s.ack = CYC_I & STB_I & ~s.ack;
      if (CYC_I & STB_I & ~s.ack) begin
         next_s.rdata = 32'h00000000;
         case (ADR_I)
            REG_RST_EXTRA: next_s.rdata[15:0] = s.rst_extra;
            REG_DRY_RATE: next_s.rdata[15:0] = s.dry_rate;
            REG_PROG_RATE: next_s.rdata[15:0] = s.prog_rate;
            REG_RAMP_STEP: next_s.rdata[15:0] = s.ramp_step;
            REG_STATUS: begin
               next_s.rdata[STAT_STATE_LSB +: 2] = s.state;
               next_s.rdata[STAT_LOCK_BIT] = s.lock_stat;
               next_s.rdata[STAT_NOTIFY_BIT] = s.notify;
               next_s.rdata[STAT_START_BIT] = s.lamps.start;
               next_s.rdata[STAT_HOLD_BIT] = s.lamps.hold;
               next_s.rdata[STAT_RUN_BIT] = s.lamps.running;
               next_s.rdata[STAT_STROBE_LSB +: 3] = s.strobes;
               next_s.rdata[STAT_RATE_LSB +: 16] = s.rate;
            end
            default: next_s.rdata = 32'h00000000;
         endcase
      end
      // Writes land on the edge where the master sees ack
      if (CYC_I & STB_I & WE_I & s.ack) begin
         case (ADR_I)
            REG_RST_EXTRA: next_s.rst_extra = wmerge(s.rst_extra, DAT_I, SEL_I);
            REG_DRY_RATE: next_s.dry_rate = wmerge(s.dry_rate, DAT_I, SEL_I);
            REG_PROG_RATE: next_s.prog_rate = wmerge(s.prog_rate, DAT_I, SEL_I);
            REG_RAMP_STEP: next_s.ramp_step = wmerge(s.ramp_step, DAT_I, SEL_I);
            default: next_s.rdata = s.rdata;
         endcase
      end
   end

   // State register
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         s <= CTL_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign DAT_O = s.rdata;
   assign ACK_O = s.ack;
   assign CYCLE_START_LAMP_O = s.lamps.start;
   assign FEED_HOLD_LAMP_O = s.lamps.hold;
   assign AUTO_RUNNING_O = s.lamps.running;
   assign RESET_NOTIFY_O = s.notify;
   assign AXIS_LOCK_STATUS_O = s.lock_stat;
   assign SERVO_PULSE_EN_O = s.pulse_en;
   assign BLOCK_EXEC_EN_O = s.exec_en;
   assign MISC_CODE_STROBE_O = s.strobes[0];
   assign SPINDLE_CODE_STROBE_O = s.strobes[1];
   assign TOOL_CODE_STROBE_O = s.strobes[2];
   assign FEED_RATE_O = s.rate;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);

   chk_start_entry: assert property (
      start_fall && s.state == OP_STOP && auto_mode && FEED_HOLD_N_I
      && EMERGENCY_STOP_N_I && !RESET_KEY_I && !RESET_AND_REWIND_I
      && !ALARM_I && !PROGRAM_RESTART_I && !SEQ_SEARCH_I
      |=> s.state == OP_START ##0 AUTO_RUNNING_O)
      else $error("start edge did not start operation");

   chk_start_veto: assert property (
      scan && s.state == OP_STOP && (ALARM_I || !auto_mode
      || PROGRAM_RESTART_I || SEQ_SEARCH_I || RESET_AND_REWIND_I)
      |=> s.state != OP_START)
      else $error("start taken while blocked");

   chk_hold_veto: assert property (
      scan && s.state == OP_STOP && !FEED_HOLD_N_I |=> !CYCLE_START_LAMP_O)
      else $error("start taken while feed hold low");

   chk_hold_entry: assert property (
      hold_fall && s.state == OP_START && !reset_cause
      |=> s.state == OP_HOLD && !CYCLE_START_LAMP_O && FEED_HOLD_LAMP_O)
      else $error("feed hold edge not honoured");

   chk_lamp_table: assert property (
      (s.state == OP_START) == (CYCLE_START_LAMP_O && !FEED_HOLD_LAMP_O
      && AUTO_RUNNING_O) && (s.state == OP_HOLD) == (FEED_HOLD_LAMP_O
      && AUTO_RUNNING_O))
      else $error("lamp outputs disagree with state");

   chk_reset_notify: assert property (
      scan && reset_cause |=> RESET_NOTIFY_O && s.state == OP_RESET
      && !AUTO_RUNNING_O ##0 !MISC_CODE_STROBE_O && !TOOL_CODE_STROBE_O
      && !SPINDLE_CODE_STROBE_O)
      else $error("reset not signalled");

   chk_notify_hold: assert property (
      $fell(RESET_NOTIFY_O) |-> $past(s.rst_cnt) == 17'h00000)
      else $error("notify dropped before hold time");

   chk_lock_mirror: assert property (
      ##1 AXIS_LOCK_STATUS_O == $past(AXIS_LOCK_REQUEST_I))
      else $error("lock status not mirrored");

   chk_lock_pulses: assert property (
      AXIS_LOCK_REQUEST_I && s.state == OP_START && !scan
      |=> !SERVO_PULSE_EN_O && BLOCK_EXEC_EN_O)
      else $error("pulses not held off under axis lock");

   chk_single_stop: assert property (
      scan && s.state == OP_START && BLOCK_DONE_I && SINGLE_BLOCK_REQUEST_I
      && !reset_cause && !hold_fall |=> s.state == OP_STOP)
      else $error("single block did not stop");

   chk_ramp_step: assert property (
      scan |=> (FEED_RATE_O >= $past(FEED_RATE_O)
      ? FEED_RATE_O - $past(FEED_RATE_O) : $past(FEED_RATE_O) - FEED_RATE_O)
      <= s.ramp_step || $past(CYC_I))
      else $error("speed stepped by more than one ramp step");

   // Start vetoes, leaving and resuming operation, lamps, reset notification and speed ramps
   chk_estop_veto: assert property (
      scan && s.state == OP_STOP && reset_cause |=> s.state != OP_START)
      else $error("start taken during reset cause");

   chk_hold_resume: assert property (
      s.state == OP_HOLD && !start_fall |=> s.state != OP_START)
      else $error("hold left without start edge");

   chk_hold_lamps: assert property (
      $rose(FEED_HOLD_LAMP_O) |-> !CYCLE_START_LAMP_O && s.state == OP_HOLD)
      else $error("hold lamp rose outside hold");

   chk_idle_lamps: assert property (
      s.state == OP_STOP || s.state == OP_RESET
      |-> !CYCLE_START_LAMP_O && !FEED_HOLD_LAMP_O && !AUTO_RUNNING_O)
      else $error("lamps lit while stopped");

   chk_alarm_stop: assert property (
      scan && s.state == OP_START && ALARM_I && !reset_cause && !hold_fall
      |=> s.state == OP_STOP)
      else $error("alarm did not stop");

   chk_mode_stop: assert property (
      scan && s.state == OP_START && BLOCK_DONE_I && MODE_I != s.run_mode
      && (auto_mode || MODE_I == MODE_EDIT) && !reset_cause && !hold_fall
      |=> s.state == OP_STOP)
      else $error("mode change did not stop");

   chk_mdi_stop: assert property (
      scan && s.state == OP_START && MDI_END_I && s.run_mode == MODE_MDI
      && !reset_cause && !hold_fall |=> s.state == OP_STOP)
      else $error("MDI end did not stop");

   chk_seq_run: assert property (
      scan && s.state == OP_START && BLOCK_DONE_I && !SINGLE_BLOCK_REQUEST_I
      && !ALARM_I && !MDI_END_I && MODE_I == s.run_mode && !reset_cause
      && !hold_fall |=> s.state == OP_START)
      else $error("block end stopped sequential run");

   chk_notify_kept: assert property (
      s.state == OP_RESET && s.rst_cnt != 17'h00000 |=> RESET_NOTIFY_O)
      else $error("notify dropped early");

   chk_dry_ramp: assert property (
      scan && s.state == OP_START && DRY_RUN_REQUEST_I && auto_mode
      && s.ramp_step != 16'h0000 && FEED_RATE_O < s.dry_rate
      |=> FEED_RATE_O > $past(FEED_RATE_O))
      else $error("speed not rising to dry rate");

   chk_prog_ramp: assert property (
      scan && s.state == OP_START && !DRY_RUN_REQUEST_I
      && s.ramp_step != 16'h0000 && FEED_RATE_O > s.prog_rate
      |=> FEED_RATE_O < $past(FEED_RATE_O))
      else $error("speed not falling to programmed rate");

   chk_decel_rest: assert property (
      scan && s.state == OP_RESET && s.ramp_step != 16'h0000
      && FEED_RATE_O != 16'h0000 |=> FEED_RATE_O < $past(FEED_RATE_O))
      else $error("axes not decelerating on reset");

   chk_rate_still: assert property (
      !scan |=> $stable(FEED_RATE_O))
      else $error("speed changed between scans");

endmodule // auto_operation_control
`default_nettype wire

// file: tb/auto_operation_control_tb.sv
// Self-checking bench of the automatic operation controller
`timescale 1ns/100ps
`default_nettype none
module auto_operation_control_tb;
   import auto_op_pkg::*;
   localparam int SC = 10;
   logic CLK_I, SRST_I, WE_I, CYC_I, STB_I, ACK_O, go;
   logic [7:0] ADR_I;
   logic [31:0] DAT_I, DAT_O, rd;
   logic [3:0] SEL_I;
   logic [2:0] MODE_I, CODE_STROBE_SET_I, sv;
   logic FEED_HOLD_N_I, EMERGENCY_STOP_N_I, RESET_AND_REWIND_I, RESET_KEY_I;
   logic ALARM_I, PROGRAM_RESTART_I, SEQ_SEARCH_I, BLOCK_DONE_I, MDI_END_I;
   logic AXIS_LOCK_REQUEST_I, DRY_RUN_REQUEST_I, SINGLE_BLOCK_REQUEST_I;
   logic CODE_FINISH_I, CYCLE_START_LAMP_O, FEED_HOLD_LAMP_O, AUTO_RUNNING_O;
   logic RESET_NOTIFY_O, AXIS_LOCK_STATUS_O, SERVO_PULSE_EN_O, BLOCK_EXEC_EN_O;
   logic MISC_CODE_STROBE_O, SPINDLE_CODE_STROBE_O, TOOL_CODE_STROBE_O;
   logic [15:0] FEED_RATE_O, extra;
   wire logic CYCLE_START_REQUEST_I;
   wire logic [15:0] lamps = {13'h0, CYCLE_START_LAMP_O, FEED_HOLD_LAMP_O,
      AUTO_RUNNING_O};
   wire logic [15:0] strobes = {13'h0, TOOL_CODE_STROBE_O,
      SPINDLE_CODE_STROBE_O, MISC_CODE_STROBE_O};
   // Register table: offset and reset value, last entry unmapped
   logic [7:0] ra [5] = '{REG_RST_EXTRA, REG_DRY_RATE, REG_PROG_RATE,
      REG_RAMP_STEP, 8'h14};
   logic [15:0] rv [5] = '{RST_EXTRA_RST, DRY_RATE_RST, PROG_RATE_RST,
      RAMP_STEP_RST, 16'h0000};
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int i;

   auto_operation_control #(.SCAN_CYCLES_P(SC)) dut (.CLK_I, .SRST_I, .ADR_I,
      .DAT_I, .SEL_I, .WE_I, .CYC_I, .STB_I, .DAT_O, .ACK_O, .MODE_I,
      .CYCLE_START_REQUEST_I, .FEED_HOLD_N_I, .EMERGENCY_STOP_N_I,
      .RESET_AND_REWIND_I, .RESET_KEY_I, .ALARM_I, .PROGRAM_RESTART_I,
      .SEQ_SEARCH_I, .BLOCK_DONE_I, .MDI_END_I, .AXIS_LOCK_REQUEST_I,
      .DRY_RUN_REQUEST_I, .SINGLE_BLOCK_REQUEST_I, .CODE_STROBE_SET_I,
      .CODE_FINISH_I, .CYCLE_START_LAMP_O, .FEED_HOLD_LAMP_O, .AUTO_RUNNING_O,
      .RESET_NOTIFY_O, .AXIS_LOCK_STATUS_O, .SERVO_PULSE_EN_O,
      .BLOCK_EXEC_EN_O, .MISC_CODE_STROBE_O, .SPINDLE_CODE_STROBE_O,
      .TOOL_CODE_STROBE_O, .FEED_RATE_O);

   plc_model #(.SCAN_P(SC)) plc (.clk_i(CLK_I), .rst_i(SRST_I), .go_i(go),
      .start_o(CYCLE_START_REQUEST_I));

   // 10 MHz clock
   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge CLK_I) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Values read here are those sampled at the current edge
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chf(input string nm, input logic e, input logic g);
      chk(nm, {15'h0, e}, {15'h0, g});
   endtask

   task automatic wt(input int n);
      repeat (n * SC) @(posedge CLK_I);
   endtask

   // Classic Wishbone cycle; waits for ack, then idles one cycle
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= w;
      ADR_I <= a;
      DAT_I <= d;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (ACK_O !== 1'b1);
      chk("ack wait", 16'h0002, 16'(n));
      rd = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      @(posedge CLK_I);
   endtask

   task automatic start_seq();
      go <= 1'b1;
      @(posedge CLK_I);
      go <= 1'b0;
      wt(5);
   endtask

   task automatic pulse_done();
      BLOCK_DONE_I <= 1'b1;
      wt(1);
      BLOCK_DONE_I <= 1'b0;
      wt(1);
   endtask

   // Sets one of the conditions that must block a start
   task automatic cond(input int k, input logic on);
      case (k)
         0: MODE_I <= on ? MODE_EDIT : MODE_AUTO;
         1: FEED_HOLD_N_I <= !on;
         2: EMERGENCY_STOP_N_I <= !on;
         3: RESET_AND_REWIND_I <= on;
         4: RESET_KEY_I <= on;
         5: ALARM_I <= on;
         6: PROGRAM_RESTART_I <= on;
         default: SEQ_SEARCH_I <= on;
      endcase
   endtask

   initial begin
      {WE_I, CYC_I, STB_I, go, ADR_I, DAT_I, RESET_AND_REWIND_I} = '0;
      {RESET_KEY_I, ALARM_I, PROGRAM_RESTART_I, SEQ_SEARCH_I} = '0;
      {BLOCK_DONE_I, MDI_END_I, AXIS_LOCK_REQUEST_I, CODE_FINISH_I} = '0;
      {DRY_RUN_REQUEST_I, SINGLE_BLOCK_REQUEST_I, CODE_STROBE_SET_I} = '0;
      {FEED_HOLD_N_I, EMERGENCY_STOP_N_I} = 2'h3;
      SEL_I = 4'h3;
      MODE_I = MODE_AUTO;
      SRST_I = 1'b1;
      void'($urandom(24));
      repeat (5) @(posedge CLK_I);
      SRST_I <= 1'b0;
      wt(1);
      chk("lamps", 16'h0, lamps);
      chf("notify", 1'b0, RESET_NOTIFY_O);
      // Register defaults, unmapped place and read-only status
      bus(1'b1, 8'h14, 32'h0000ffff);
      bus(1'b1, REG_STATUS, 32'h0000ffff);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status", 16'h0, {14'h0, rd[1:0]});
      for (i = 0; i < 5; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk("reg", rv[i], rd[15:0]);
      end
      extra = 16'($urandom_range(3));
      bus(1'b1, REG_RST_EXTRA, {16'h0, extra});
      bus(1'b0, REG_RST_EXTRA, 32'h0);
      chk("extra", extra, rd[15:0]);
      bus(1'b1, REG_PROG_RATE, 32'h10);
      bus(1'b1, REG_DRY_RATE, 32'h20);
      // Lock status follows the request one clock later
      for (i = 0; i < 8; i++) begin
         AXIS_LOCK_REQUEST_I <= 1'($urandom);
         repeat (2) @(posedge CLK_I);
         chf("lock", AXIS_LOCK_REQUEST_I, AXIS_LOCK_STATUS_O);
      end
      AXIS_LOCK_REQUEST_I <= 1'b0;
      // Every blocking condition, then cleared; nothing may start
      for (i = 0; i < 8; i++) begin
         cond(i, 1'b1);
         wt(2);
         start_seq();
         chk("refused", 16'h0, lamps);
         cond(i, 1'b0);
         wt(25);
         chk("still stopped", 16'h0, lamps);
      end
      start_seq();
      chk("start", 16'h5, lamps);
      chf("exec", 1'b1, BLOCK_EXEC_EN_O);
      chf("servo", 1'b1, SERVO_PULSE_EN_O);
      AXIS_LOCK_REQUEST_I <= 1'b1;
      wt(1);
      chf("locked servo", 1'b0, SERVO_PULSE_EN_O);
      chf("locked exec", 1'b1, BLOCK_EXEC_EN_O);
      AXIS_LOCK_REQUEST_I <= 1'b0;
      wt(6);
      chk("rate", 16'h10, FEED_RATE_O);
      DRY_RUN_REQUEST_I <= 1'b1;
      wt(1);
      chf("ramping", 1'b1, FEED_RATE_O < 16'h20);
      wt(5);
      chk("dry rate", 16'h20, FEED_RATE_O);
      DRY_RUN_REQUEST_I <= 1'b0;
      wt(6);
      chk("rate back", 16'h10, FEED_RATE_O);
      // Hold, release, restart
      FEED_HOLD_N_I <= 1'b0;
      wt(2);
      chk("hold", 16'h3, lamps);
      FEED_HOLD_N_I <= 1'b1;
      wt(3);
      chk("hold kept", 16'h3, lamps);
      start_seq();
      chk("restart", 16'h5, lamps);
      SINGLE_BLOCK_REQUEST_I <= 1'b1;
      wt(2);
      chk("block busy", 16'h5, lamps);
      pulse_done();
      chk("block stop", 16'h0, lamps);
      SINGLE_BLOCK_REQUEST_I <= 1'b0;
      start_seq();
      pulse_done();
      chk("sequential", 16'h5, lamps);
      ALARM_I <= 1'b1;
      wt(2);
      chk("alarm stop", 16'h0, lamps);
      ALARM_I <= 1'b0;
      start_seq();
      // Finish clears the strobes, but a set in the same clock wins
      sv = 3'($urandom_range(7, 1));
      CODE_STROBE_SET_I <= sv;
      CODE_FINISH_I <= 1'b1;
      @(posedge CLK_I);
      CODE_STROBE_SET_I <= 3'h0;
      @(posedge CLK_I);
      chk("set wins", {13'h0, sv}, strobes);
      @(posedge CLK_I);
      CODE_FINISH_I <= 1'b0;
      @(posedge CLK_I);
      chk("finish clr", 16'h0, strobes);
      // Reset with strobes pending
      sv = 3'($urandom_range(7, 1));
      CODE_STROBE_SET_I <= sv;
      @(posedge CLK_I);
      CODE_STROBE_SET_I <= 3'h0;
      @(posedge CLK_I);
      chk("strobes", {13'h0, sv}, strobes);
      EMERGENCY_STOP_N_I <= 1'b0;
      wt(2);
      chk("reset lamps", 16'h0, lamps);
      chf("notify", 1'b1, RESET_NOTIFY_O);
      chk("strobes clr", 16'h0, strobes);
      wt(6);
      chk("decel", 16'h0, FEED_RATE_O);
      EMERGENCY_STOP_N_I <= 1'b1;
      wt(15 + int'(extra));
      chf("notify held", 1'b1, RESET_NOTIFY_O);
      wt(3);
      chf("notify end", 1'b0, RESET_NOTIFY_O);
      MODE_I <= MODE_MDI;
      start_seq();
      chk("mdi start", 16'h5, lamps);
      MDI_END_I <= 1'b1;
      wt(2);
      chk("mdi end", 16'h0, lamps);
      MDI_END_I <= 1'b0;
      // Mode change waits for the block to end
      start_seq();
      MODE_I <= MODE_EDIT;
      wt(2);
      chk("mode wait", 16'h5, lamps);
      pulse_done();
      chk("mode stop", 16'h0, lamps);
      results();
   end
endmodule // auto_operation_control_tb
`default_nettype wire

// file: tb/plc_model.sv
// Machine-side PLC model that issues the cycle start request sequence
`timescale 1ns/100ps
`default_nettype none
module plc_model #(
   parameter int SCAN_P = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   output logic start_o
);
   int hold_cnt;
   // Request stays high three scans so one scan surely sees it high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_o <= 1'b0;
         hold_cnt <= 0;
      end else if (go_i) begin
         start_o <= 1'b1;
         hold_cnt <= 3 * SCAN_P;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
         start_o <= (hold_cnt != 1); // Fall ends the sequence
      end
   end
endmodule // plc_model
`default_nettype wire
